// file: rtl/spi_mgmt_pkg.sv
// constants for the serial management link target: header fields, byte codes,
// register map and hold-off timing.
// assumes a 100 MHz aclk and a link clock sampled as an ordinary input.
package spi_mgmt_pkg;
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned NV_HOLDOFF_MS = 80;
  localparam int unsigned V_HOLDOFF_MS  = 10;
  localparam int unsigned NV_HOLDOFF_CYC_DEF = NV_HOLDOFF_MS * (CLK_HZ / 1000);
  localparam int unsigned V_HOLDOFF_CYC_DEF  = V_HOLDOFF_MS * (CLK_HZ / 1000);
  localparam int unsigned HOLD_W        = 23;
  // header bit positions once all 32 bits are shifted in, first bit at the top
  localparam int unsigned RW_BIT  = 31;
  localparam int unsigned BANK_HI = 30;
  localparam int unsigned BANK_LO = 27;
  localparam int unsigned SIZE_HI = 26;
  localparam int unsigned SIZE_LO = 16;
  localparam int unsigned PAGE_HI = 15;
  localparam int unsigned PAGE_LO = 8;
  localparam int unsigned BYTE_HI = 7;
  localparam int unsigned BYTE_LO = 0;
  localparam logic [1:0]  HDR_LAST  = 2'h3;
  localparam logic [2:0]  LAST_BIT  = 3'h7;
  localparam logic [7:0]  ACK_BYTE  = 8'h00;
  localparam logic [7:0]  NACK_BYTE = 8'hFF;
  localparam logic [7:0]  FILL_BYTE = 8'h00;
  // register map, byte addresses
  localparam int unsigned ADDR_W     = 8;
  localparam logic [7:0]  REG_CTRL   = 8'h00;
  localparam logic [7:0]  REG_FLOW   = 8'h04;
  localparam logic [7:0]  REG_NVBANK = 8'h08;
  localparam logic [7:0]  REG_STATUS = 8'h0C;
  localparam logic [7:0]  REG_HEADER = 8'h10;
  localparam logic [7:0]  REG_COUNT  = 8'h14;
  localparam logic        ENABLE_RST = 1'h1;
  localparam logic [7:0]  FLOW_RST   = 8'h02;
  localparam logic [15:0] NVBANK_RST = 16'h0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage : spi_mgmt_pkg

// file: rtl/spi_mgmt_target.sv
// serial management link target with an AXI4-Lite register slave.
// assumes the link pins are asynchronous to aclk and are oversampled; the
// management memory answers mem_rdata one aclk after mem_rd.
`timescale 1ns/10ps
module spi_mgmt_target
  import spi_mgmt_pkg::*;
#(
  parameter int unsigned NV_HOLDOFF_CYC = NV_HOLDOFF_CYC_DEF,
  parameter int unsigned V_HOLDOFF_CYC  = V_HOLDOFF_CYC_DEF
) (
  input  wire logic              aclk,                        // 100 MHz clock
  input  wire logic              aresetn,                     // sync reset, low
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,                // write address
  input  wire logic              s_axi_awvalid,               // write address valid
  output logic                   s_axi_awready,               // write address ready
  input  wire logic [31:0]       s_axi_wdata,                 // write data
  input  wire logic [3:0]        s_axi_wstrb,                 // byte enables
  input  wire logic              s_axi_wvalid,                // write data valid
  output logic                   s_axi_wready,                // write data ready
  output logic [1:0]             s_axi_bresp,                 // write response
  output logic                   s_axi_bvalid,                // write response valid
  input  wire logic              s_axi_bready,                // write response ready
  input  wire logic [ADDR_W-1:0] s_axi_araddr,                // read address
  input  wire logic              s_axi_arvalid,               // read address valid
  output logic                   s_axi_arready,               // read address ready
  output logic [31:0]            s_axi_rdata,                 // read data
  output logic [1:0]             s_axi_rresp,                 // read response
  output logic                   s_axi_rvalid,                // read data valid
  input  wire logic              s_axi_rready,                // read data ready
  input  wire logic              link_clk,                    // link clock pin
  input  wire logic              target_select_n,             // select, low
  input  wire logic              initiator_to_target_data,    // serial in
  output logic                   target_to_initiator_data,    // serial out
  output logic                   target_to_initiator_data_oe, // drive enable
  output logic                   mem_rd,                      // read pulse
  output logic                   mem_wr,                      // write pulse
  output logic [19:0]            mem_addr,                    // bank,page,byte
  output logic [7:0]             mem_wdata,                   // write byte
  input  wire logic [7:0]        mem_rdata                    // read byte, +1 cycle
);

  typedef enum logic [2:0] {PH_IDLE, PH_HEADER, PH_FLOW, PH_DATA, PH_OVER} phase_t;

  typedef struct packed {
    logic              cs_m, cs_s, sck_m, sck_s, sck_d, mosi_m, mosi_s;
    logic              active;
    phase_t            phase;
    logic [2:0]        bit_cnt;
    logic [10:0]       cnt;
    logic [7:0]        rx_sr, tx_sr;
    logic              miso, miso_oe;
    logic [31:0]       hdr;
    logic [7:0]        addr;
    logic              accepted, wrote;
    logic              mem_rd, mem_wr, rd_pend;
    logic [19:0]       mem_addr;
    logic [7:0]        mem_wdata, rd_buf;
    logic [HOLD_W-1:0] hold_cnt;
    logic              hold_nv;
    logic              enable;
    logic [7:0]        flow_n;
    logic [15:0]       nv_banks, txn_cnt, abort_cnt;
    logic [ADDR_W-1:0] awaddr;
    logic              aw_got, w_got;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              awready, wready, bvalid, arready, rvalid;
    logic [1:0]        bresp, rresp;
    logic [31:0]       rdata;
  } state_t;

  state_t s;
  state_t next_s;

  // full memory location: bank and page ride in every header, no select registers
  function automatic logic [19:0] loc(input logic [31:0] h, input logic [7:0] a);
    loc = {h[BANK_HI:BANK_LO], h[PAGE_HI:PAGE_LO], a};
  endfunction : loc

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : merge

  function automatic logic reg_known(input logic [ADDR_W-1:0] a);
    reg_known = (a == REG_CTRL) || (a == REG_FLOW) || (a == REG_NVBANK) ||
                (a == REG_STATUS) || (a == REG_HEADER) || (a == REG_COUNT);
  endfunction : reg_known

  always_comb begin
    logic       bit_in;
    logic [7:0] byte_in;
    logic [7:0] tx;
    logic [7:0] flow_last;
    logic [31:0] m;
    bit_in    = 1'b0;
    byte_in   = 8'h00;
    tx        = FILL_BYTE;
    flow_last = (s.flow_n == 8'h00) ? 8'h00 : s.flow_n - 8'h01;
    m         = 32'h0000_0000;
    next_s    = s;
    next_s.mem_rd  = 1'b0;
    next_s.mem_wr  = 1'b0;
    next_s.rd_pend = s.mem_rd; // read byte stands the cycle after the strobe
    // pin synchronisers; the second stage is looked at, and on the link clock a third stage as well for edge detection
    next_s.cs_m   = target_select_n;
    next_s.cs_s   = s.cs_m;
    next_s.sck_m  = link_clk;
    next_s.sck_s  = s.sck_m;
    next_s.sck_d  = s.sck_s;
    next_s.mosi_m = initiator_to_target_data;
    next_s.mosi_s = s.mosi_m;
    // write cycle timer runs from the stop onward
    if (s.hold_cnt != '0) next_s.hold_cnt = s.hold_cnt - 1'b1;
    if (s.rd_pend) next_s.rd_buf = mem_rdata;

    // link framing and bit engine
    if (!s.active && !s.cs_s) begin
      next_s.active   = 1'b1;
      next_s.miso_oe  = 1'b1;
      next_s.miso     = 1'b0;
      next_s.phase    = PH_HEADER;
      next_s.cnt      = '0;
      next_s.bit_cnt  = '0;
      next_s.tx_sr    = FILL_BYTE;
      next_s.hdr      = '0;
      next_s.accepted = 1'b0;
      next_s.wrote    = 1'b0;
    end else if (s.active && s.cs_s) begin
      // stop or abort: release the line and drop any partial byte
      next_s.active  = 1'b0;
      next_s.miso_oe = 1'b0;
      next_s.miso    = 1'b0;
      next_s.phase   = PH_IDLE;
      next_s.bit_cnt = '0;
      next_s.txn_cnt = s.txn_cnt + 16'h0001;
      if (s.phase != PH_OVER || s.bit_cnt != '0) next_s.abort_cnt = s.abort_cnt + 16'h0001;
      if (s.wrote) begin
        // hold-off sized by the bank's storage kind; no edge is lost if a
        // new start arrives, the flow answer simply stays busy
        next_s.hold_nv  = s.nv_banks[s.hdr[BANK_HI:BANK_LO]];
        next_s.hold_cnt = next_s.hold_nv ? HOLD_W'(NV_HOLDOFF_CYC)
                                         : HOLD_W'(V_HOLDOFF_CYC);
      end
      next_s.wrote = 1'b0;
    end else if (s.active && s.sck_s && !s.sck_d) begin
      // rising link edge: sample one bit in and move one bit out
      bit_in         = s.mosi_s;
      byte_in        = {s.rx_sr[6:0], bit_in};
      next_s.rx_sr   = byte_in;
      next_s.bit_cnt = s.bit_cnt + 3'h1;
      if (s.phase == PH_HEADER) next_s.hdr = {s.hdr[30:0], bit_in};
      if (s.bit_cnt != LAST_BIT) begin
        next_s.miso  = s.tx_sr[7];
        next_s.tx_sr = {s.tx_sr[6:0], 1'b0};
      end else begin
        case (s.phase)
          PH_HEADER: begin
            if (s.cnt[1:0] == HDR_LAST) begin
              // header complete: decode and decide accept now
              next_s.phase    = PH_FLOW;
              next_s.cnt      = '0;
              next_s.accepted = s.enable && (s.hold_cnt == '0);
              next_s.addr     = next_s.hdr[BYTE_HI:BYTE_LO];
              tx = next_s.accepted ? ACK_BYTE : NACK_BYTE;
              if (next_s.accepted && next_s.hdr[RW_BIT]) begin
                next_s.mem_rd   = 1'b1;
                next_s.mem_addr = loc(next_s.hdr, next_s.addr);
                next_s.addr     = next_s.addr + 8'h01;
              end
            end else begin
              next_s.cnt = s.cnt + 11'h001;
            end
          end
          PH_FLOW: begin
            // flow bytes from the initiator are ignored
            if (s.cnt[7:0] == flow_last) begin
              next_s.phase = PH_DATA;
              next_s.cnt   = '0;
              if (s.accepted && s.hdr[RW_BIT]) begin
                tx = s.rd_buf;
                if (s.hdr[SIZE_HI:SIZE_LO] != 11'h000) begin
                  next_s.mem_rd   = 1'b1;
                  next_s.mem_addr = loc(s.hdr, s.addr);
                  next_s.addr     = s.addr + 8'h01;
                end
              end
            end else begin
              next_s.cnt = s.cnt + 11'h001;
              tx = s.accepted ? ACK_BYTE : NACK_BYTE;
            end
          end
          PH_DATA: begin
            if (s.accepted && !s.hdr[RW_BIT]) begin
              next_s.mem_wr    = 1'b1;
              next_s.mem_addr  = loc(s.hdr, s.addr);
              next_s.mem_wdata = byte_in;
              next_s.addr      = s.addr + 8'h01;
              next_s.wrote     = 1'b1;
            end
            if (s.cnt == s.hdr[SIZE_HI:SIZE_LO]) begin
              next_s.phase = PH_OVER;
            end else begin
              next_s.cnt = s.cnt + 11'h001;
              if (s.accepted && s.hdr[RW_BIT]) begin
                tx = s.rd_buf;
                if (s.cnt + 11'h001 != s.hdr[SIZE_HI:SIZE_LO]) begin
                  next_s.mem_rd   = 1'b1;
                  next_s.mem_addr = loc(s.hdr, s.addr);
                  next_s.addr     = s.addr + 8'h01;
                end
              end
            end
          end
          PH_OVER: tx = FILL_BYTE;
          default: tx = FILL_BYTE;
        endcase
        next_s.miso  = tx[7];
        next_s.tx_sr = {tx[6:0], 1'b0};
      end
    end

    // axi4-lite write: address and data in either order, response after both
    if (s.bvalid && s_axi_bready) next_s.bvalid = 1'b0;
    if (s_axi_awvalid && s.awready) begin
      next_s.awaddr = s_axi_awaddr;
      next_s.aw_got = 1'b1;
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.wdata  = s_axi_wdata;
      next_s.wstrb  = s_axi_wstrb;
      next_s.w_got  = 1'b1;
    end
    if (next_s.aw_got && next_s.w_got && !s.bvalid) begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = reg_known(next_s.awaddr) ? RESP_OKAY : RESP_SLVERR;
      case (next_s.awaddr)
        REG_CTRL: begin
          m = merge({31'h0, s.enable}, next_s.wdata, next_s.wstrb);
          next_s.enable = m[0];
        end
        REG_FLOW: begin
          m = merge({24'h0, s.flow_n}, next_s.wdata, next_s.wstrb);
          next_s.flow_n = m[7:0];
        end
        REG_NVBANK: begin
          m = merge({16'h0, s.nv_banks}, next_s.wdata, next_s.wstrb);
          next_s.nv_banks = m[15:0];
        end
        default: m = 32'h0000_0000;
      endcase
    end
    next_s.awready = !next_s.aw_got && !next_s.bvalid;
    next_s.wready  = !next_s.w_got && !next_s.bvalid;

    // axi4-lite read: one outstanding, unmapped reads return zero with slverr
    if (s.rvalid && s_axi_rready) next_s.rvalid = 1'b0;
    if (s_axi_arvalid && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = reg_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        REG_CTRL:   next_s.rdata = {31'h0, s.enable};
        REG_FLOW:   next_s.rdata = {24'h0, s.flow_n};
        REG_NVBANK: next_s.rdata = {16'h0, s.nv_banks};
        REG_STATUS: next_s.rdata = {28'h0, s.hold_nv, s.accepted, s.active,
                                    s.hold_cnt != '0};
        REG_HEADER: next_s.rdata = s.hdr;
        REG_COUNT:  next_s.rdata = {s.abort_cnt, s.txn_cnt};
        default:    next_s.rdata = 32'h0000_0000;
      endcase
    end
    next_s.arready = !next_s.rvalid;
  end

  // single state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s          <= '0;
      s.cs_m     <= 1'b1;
      s.cs_s     <= 1'b1;
      s.phase    <= PH_IDLE;
      s.enable   <= ENABLE_RST;
      s.flow_n   <= FLOW_RST;
      s.nv_banks <= NVBANK_RST;
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_awready               = s.awready;
  assign s_axi_wready                = s.wready;
  assign s_axi_bvalid                = s.bvalid;
  assign s_axi_bresp                 = s.bresp;
  assign s_axi_arready               = s.arready;
  assign s_axi_rvalid                = s.rvalid;
  assign s_axi_rdata                 = s.rdata;
  assign s_axi_rresp                 = s.rresp;
  assign target_to_initiator_data    = s.miso;
  assign target_to_initiator_data_oe = s.miso_oe;
  assign mem_rd                      = s.mem_rd;
  assign mem_wr                      = s.mem_wr;
  assign mem_addr                    = s.mem_addr;
  assign mem_wdata                   = s.mem_wdata;

  // checks on the link engine and the axi write response
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  release_stop_a: assert property ((s.active && s.cs_s) |=> (!s.miso_oe && s.phase == PH_IDLE
                                   && s.bit_cnt == 3'h0))
    else $error("line not released or parser not reset after deselect");
  busy_nack_a: assert property ((s.phase == PH_HEADER && next_s.phase == PH_FLOW
                                && s.hold_cnt != '0) |=> !s.accepted)
    else $error("transaction accepted during write hold-off");
  nv_bound_a: assert property (s.hold_cnt <= HOLD_W'(NV_HOLDOFF_CYC))
    else $error("non-volatile hold-off above its limit");
  v_bound_a: assert property (!s.hold_nv |-> s.hold_cnt <= HOLD_W'(V_HOLDOFF_CYC))
    else $error("volatile hold-off above its limit");
  hold_start_a: assert property ((s.active && s.cs_s && s.wrote) |=> (s.hold_cnt != '0))
    else $error("write not followed by hold-off");
  over_quiet_a: assert property ($past(s.phase) == PH_OVER |-> (!s.mem_wr && !s.mem_rd))
    else $error("memory touched beyond announced length");
  write_dir_a: assert property (s.mem_wr |-> (!s.hdr[RW_BIT] && s.accepted ##1 !s.mem_wr))
    else $error("write pulse on a read or longer than one cycle");
  read_dir_a: assert property (s.mem_rd |-> s.hdr[RW_BIT] ##1 !s.mem_rd)
    else $error("read pulse on a write or longer than one cycle");
  bank_page_a: assert property ((s.mem_rd || s.mem_wr) |-> s.mem_addr[19:8] ==
                                {s.hdr[BANK_HI:BANK_LO], s.hdr[PAGE_HI:PAGE_LO]})
    else $error("memory access outside header bank and page");
  addr_step_a: assert property ((s.mem_wr ##[1:200] s.mem_wr) |->
                                s.mem_addr[7:0] == $past(s.addr))
    else $error("write address did not follow the pointer");
  bresp_hold_a: assert property ((s.bvalid && !s_axi_bready) |=> s.bvalid)
    else $error("write response dropped before accepted");

  read_seen_c: cover property (s.phase == PH_DATA && s.hdr[RW_BIT] && s.mem_rd);
  write_hold_c: cover property (s.active && s.cs_s && s.wrote);
  abort_c: cover property (s.active && s.cs_s && s.phase == PH_HEADER);
  nack_c: cover property (s.phase == PH_FLOW && !s.accepted);

endmodule : spi_mgmt_target

// file: dv/spi_initiator_model.sv
// serial initiator model: makes the link clock, select and outbound data
// assumes the bench calls frame() and nothing else drives these lines
`timescale 1ns/10ps
module spi_initiator_model (
  output logic            link_clk,                    // link clock, low outside frames
  output logic            target_select_n,             // select, active low
  output logic            initiator_to_target_data,    // serial out to target
  input  wire logic       target_to_initiator_data,    // serial in from target
  input  wire logic       target_to_initiator_data_oe  // target drive enable
);
  // idle: clock stands still, select released
  initial begin
    link_clk = 1'b0;
    target_select_n = 1'b1;
    initiator_to_target_data = 1'b0;
  end
  // one frame at 8 MHz, MSB first; data moves half a bit early so the
  // oversampling target sees it settled at the rising edge.
  // one fixed rate: the target advertises no speeds, so slow start has nothing to switch
  task automatic frame(input logic [127:0] tx, input int nbits, output logic [127:0] rx);
    logic last;
    rx = '0;
    last = 1'b0;
    target_select_n <= 1'b0;
    for (int i = 0; i < nbits; i++) begin
      initiator_to_target_data <= tx[127-i];
      #62.5;
      link_clk <= 1'b1;
      // undriven line shows the inverse of the last bit
      rx[127-i] = target_to_initiator_data_oe ? target_to_initiator_data : !last;
      last = rx[127-i];
      #62.5;
      link_clk <= 1'b0;
    end
    #62.5;
    target_select_n <= 1'b1;
    initiator_to_target_data <= !initiator_to_target_data;
  endtask : frame
endmodule : spi_initiator_model

// file: dv/spi_mgmt_target_tb.sv
// self-checking bench: AXI4-Lite register access plus link transactions
// assumes hold-off counts shortened to 6000 and 2000 cycles
`timescale 1ns/10ps
module spi_mgmt_target_tb;
  import spi_mgmt_pkg::*;
  localparam int unsigned NV_C = 6000;
  localparam int unsigned V_C  = 2000;
  logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, mem_rdata = 8'h00, mem_wdata;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, lclk, sel_n, tdi, tdo, oe;
  logic        mem_rd, mem_wr;
  logic [19:0] mem_addr;
  logic [7:0]  mem [logic [19:0]];
  int          fails = 0, n_compared = 0, n_wr = 0;
  always #5 aclk = ~aclk;
  spi_mgmt_target #(.NV_HOLDOFF_CYC(NV_C), .V_HOLDOFF_CYC(V_C)) i_spi_mgmt_target (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link_clk(lclk),
    .target_select_n(sel_n), .initiator_to_target_data(tdi),
    .target_to_initiator_data(tdo), .target_to_initiator_data_oe(oe), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  spi_initiator_model i_spi_initiator_model (.link_clk(lclk), .target_select_n(sel_n),
    .initiator_to_target_data(tdi), .target_to_initiator_data(tdo),
    .target_to_initiator_data_oe(oe));
  // byte store behind the target, read data one cycle after the strobe
  always @(posedge aclk) begin
    if (mem_wr) begin
      mem[mem_addr] = mem_wdata;
      n_wr++;
    end
    if (mem_rd) mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 8'h00;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one AXI4-Lite access; handshakes peeked at the falling edge, which
  // equals what the next rising edge samples
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic [1:0] r);
    logic ha, hw, hb;
    int t;
    t = 0;
    hb = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= wr;
    wvalid <= wr;
    bready <= wr;
    arvalid <= !wr;
    rready <= !wr;
    while (!hb && t < 100) begin
      @(negedge aclk);
      t++;
      ha = awvalid && awready || arvalid && arready;
      hw = wvalid && wready;
      hb = bvalid && bready || rvalid && rready;
      q = rdata;
      r = wr ? bresp : rresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (ha) arvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) bready <= 1'b0;
      if (hb) rready <= 1'b0;
    end
    chk(t < 100, 1);
  endtask : axi
  function automatic logic [7:0] rb(input logic [127:0] rx, input int j);
    return rx[127-8*j -: 8];
  endfunction : rb
  // header, two flow bytes (FLOW reset value), data, zero padding
  task automatic txn(input logic rd, input logic [3:0] bk, input logic [7:0] pg,
                     input logic [7:0] by, input int m, input logic [31:0] wd,
                     input int nb, output logic [127:0] rx);
    i_spi_initiator_model.frame({rd, bk, 11'(m-1), pg, by, 16'h0, rd ? 32'h0 : wd, 48'h0},
                                nb, rx);
    repeat (20) @(posedge aclk);
  endtask : txn
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  initial begin
    #600_000;
    fails++;
    finish_test();
  end
  initial begin
    logic [127:0] rx;
    logic [31:0] q, wd;
    logic [1:0] r;
    logic [3:0] bk;
    logic [7:0] pg, by;
    void'($urandom(32'h1501BA67));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    axi(0, REG_FLOW, 0, q, r);
    chk(q, 32'h2);
    axi(0, 8'h1C, 0, q, r);
    chk(r, RESP_SLVERR);
    axi(1, 8'h1C, 0, q, r);
    chk(r, RESP_SLVERR);
    // write with one byte overrun, then a read inside and after the hold-off
    for (int k = 0; k < 3; k++) begin
      bk = 4'($urandom);
      pg = 8'($urandom);
      by = k == 0 ? 8'hFE : 8'($urandom);
      wd = $urandom;
      txn(0, bk, pg, by, 3, wd, 80, rx);
      chk(rb(rx, 5), ACK_BYTE);
      for (int j = 0; j < 3; j++) chk(mem[{bk, pg, 8'(by + j)}], wd[31-8*j -: 8]);
      chk(n_wr, 3 * (k + 1));
      axi(0, REG_HEADER, 0, q, r);
      chk(q, {1'b0, bk, 11'h2, pg, by});
      txn(1, bk, pg, by, 3, 0, 80, rx);
      chk(rb(rx, 5), NACK_BYTE);
      repeat (V_C) @(posedge aclk);
      txn(1, bk, pg, by, 3, 0, 80, rx);
      chk(rb(rx, 5), ACK_BYTE);
      for (int j = 0; j < 3; j++) chk(rb(rx, 6 + j), wd[31-8*j -: 8]);
    end
    // non-volatile bank: still refused after the volatile span
    axi(1, REG_NVBANK, 32'h1 << bk, q, r);
    txn(0, bk, pg, by, 1, wd, 56, rx);
    repeat (2500) @(posedge aclk);
    txn(1, bk, pg, by, 1, 0, 64, rx);
    chk(rb(rx, 5), NACK_BYTE);
    repeat (NV_C) @(posedge aclk);
    // early release mid-header, then a clean read
    txn(0, bk, pg, by, 1, 0, 13, rx);
    txn(1, bk, pg, by, 1, 0, 64, rx);
    chk(rb(rx, 5), ACK_BYTE);
    chk(rb(rx, 6), wd[31:24]);
    chk(n_wr, 10);
    axi(1, REG_CTRL, 0, q, r);
    chk(r, RESP_OKAY);
    txn(1, bk, pg, by, 1, 0, 64, rx);
    chk(rb(rx, 5), NACK_BYTE);
    // fourteen frames so far, only the mid-header one cut short
    axi(0, REG_COUNT, 0, q, r);
    chk(q, 32'h0001_000E);
    finish_test();
  end
endmodule : spi_mgmt_target_tb
